// ===== src/cawd_params.svh
// Constants for the counter-array watchdog: offsets, fields, reset values and counts.
// Functional notes
// - Reset the system on low-byte overflow while the compare byte matches the high byte.
// - While the watchdog is enabled, writing one to its module flag forces a reset.
// - While the watchdog is enabled, timebase and idle suspension writes are ignored.
// - The watchdog is enabled when the enable bit or the lock bit is set.
// - Once locked, the watchdog cannot be disabled until the next reset.
// - With the lock clear, writing zero to the enable bit disables the watchdog.
// - Reset enables the watchdog, selects clock over 12, clears low byte and offset.
// - Default watchdog timeout is 256 counter clocks, 3072 system clocks.
// - Overflow flag sets on 0xFFFF to 0x0000 wrap and only software clears it.
// - A set overflow flag with its enable raises the array interrupt.
// - Run bit 6 stops the counter at zero and lets it count at one.
// - Control bit 5 reads zero and ignores writes.
// - Module flags set on a match, raise the interrupt if enabled, software clears.
// - Any update write loads high byte plus offset, ignoring the written value.
// - While enabled, the counter runs regardless of run bit and counter writes are blocked.
// - Timebase: over 12, over 4, timer overflow, input falls, clock, external over 8.
// - While the enable bit is one, writes to other mode bits are ignored.
`ifndef CAWD_PARAMS_SVH
`define CAWD_PARAMS_SVH
`define CAWD_OFF_CTRL 8'hD8
`define CAWD_OFF_MODE 8'hDC
`define CAWD_OFF_CNT_LO 8'hE0
`define CAWD_OFF_CNT_HI 8'hE4
`define CAWD_OFF_WD_OFS 8'hE8
`define CAWD_OFF_WD_UPD 8'hEC
`define CAWD_OFF_IRQ_ST 8'hF0
`define CAWD_OFF_IRQ_MSK 8'hF4
`define CAWD_OFF_MOD_IE 8'hF8
`define CAWD_CTRL_OVF 7
`define CAWD_CTRL_RUN 6
`define CAWD_CTRL_WDF 4
`define CAWD_MODE_IDLE 7
`define CAWD_MODE_WATCHDOG_ENABLE_BIT 6
`define CAWD_MODE_LOCK 5
`define CAWD_MODE_CPS_LSB 1
`define CAWD_MODE_ECF 0
`define CAWD_MODE_RST 8'h40
`define CAWD_BYTE_RST 8'h00
`define CAWD_CNT_RST 16'h0000
`define CAWD_CNT_MAX 16'hFFFF
`define CAWD_LO_MAX 8'hFF
`define CAWD_TB_DIV12 3'h0
`define CAWD_TB_DIV4 3'h1
`define CAWD_TB_T0 3'h2
`define CAWD_TB_ECI 3'h3
`define CAWD_TB_SYS 3'h4
`define CAWD_TB_EXT8 3'h5
`define CAWD_DIV12_TOP 4'hB
`define CAWD_DIV4_TOP 4'h3
`define CAWD_EXT8_TOP 3'h7
`define CAWD_NUM_MOD 5
`define CAWD_WD_MOD 4
`define CAWD_NUM_EV 6
`define CAWD_WD_TICKS 256
`define CAWD_WD_SYSCLKS 3072
`endif

// ===== src/cawd_pkg.sv
// Types shared by the counter-array watchdog modules.
package cawd_pkg;
  typedef logic [7:0] cawd_byte_t;
  typedef logic [7:0] cawd_addr_t;
  typedef logic [31:0] cawd_word_t;
  typedef logic [2:0] cawd_tbsel_t;
endpackage

// ===== src/cawd_regbus_if.sv
// Internal register bus between the APB slave and the watchdog core.
`timescale 1ns/1ps
`default_nettype none
interface cawd_regbus_if;
  logic wr;
  cawd_pkg::cawd_addr_t addr;
  cawd_pkg::cawd_byte_t wdata;
  cawd_pkg::cawd_byte_t rdata;
  logic hit;
  modport slave (output wr, output addr, output wdata, input rdata, input hit);
  modport core (input wr, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ===== src/cawd_timebase.sv
// Counter timebase selection: prescalers, timer overflow and synchronised pins.
`timescale 1ns/1ps
`default_nettype none
`include "cawd_params.svh"
module cawd_timebase (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire cawd_pkg::cawd_tbsel_t sel_i,
  input wire logic timer0_ovf_i,
  input wire logic eci_i,
  input wire logic ext_clk_i,
  output logic tick_o
);
  import cawd_pkg::*;
  logic [2:0] eci_sync_q;
  logic [2:0] ext_sync_q;
  logic [3:0] pre_q;
  logic [2:0] ext_cnt_q;

  // Stage 0 of each synchroniser is read only by stage 1; edges use stages 1 and 2.
  wire eci_fall = eci_sync_q[2] & ~eci_sync_q[1];
  wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
  wire [3:0] pre_top = (sel_i == `CAWD_TB_DIV4) ? `CAWD_DIV4_TOP : `CAWD_DIV12_TOP;
  wire pre_wrap = (pre_q >= pre_top);
  wire ext_wrap = ext_rise & (ext_cnt_q == `CAWD_EXT8_TOP);

  assign tick_o = (sel_i == `CAWD_TB_DIV12 || sel_i == `CAWD_TB_DIV4) ? pre_wrap :
                  (sel_i == `CAWD_TB_T0) ? timer0_ovf_i :
                  (sel_i == `CAWD_TB_ECI) ? eci_fall :
                  (sel_i == `CAWD_TB_SYS) ? 1'b1 :
                  (sel_i == `CAWD_TB_EXT8) ? ext_wrap : 1'b0;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      eci_sync_q <= 3'h7;
      ext_sync_q <= 3'h0;
      pre_q <= 4'h0;
      ext_cnt_q <= 3'h0;
    end else begin
      eci_sync_q <= {eci_sync_q[1:0], eci_i};
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_i};
      pre_q <= pre_wrap ? 4'h0 : pre_q + 4'h1;
      ext_cnt_q <= ext_rise ? ext_cnt_q + 3'h1 : ext_cnt_q;
    end
  end
endmodule
`default_nettype wire

// ===== src/cawd_apb.sv
// APB slave with no wait states that feeds the internal register bus.
`timescale 1ns/1ps
`default_nettype none
module cawd_apb (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire cawd_pkg::cawd_addr_t paddr_i,
  input wire cawd_pkg::cawd_word_t pwdata_i,
  output cawd_pkg::cawd_word_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  cawd_regbus_if.slave bus
);
  import cawd_pkg::*;
  cawd_word_t prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Read data and the error answer are captured in the setup cycle.
  wire setup = psel_i & ~penable_i;
  assign bus.addr = paddr_i;
  assign bus.wdata = pwdata_i[7:0];
  assign bus.wr = psel_i & penable_i & pwrite_i & pready_q & bus.hit;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~bus.hit;
      prdata_q <= (setup & ~pwrite_i & bus.hit) ? {24'h000000, bus.rdata} : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ===== src/cawd_top.sv
// Counter array with its last compare module working as a watchdog, APB registers and interrupts.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cawd_params.svh"
module cawd_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire cawd_pkg::cawd_addr_t paddr_i,
  input wire cawd_pkg::cawd_word_t pwdata_i,
  output cawd_pkg::cawd_word_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic timer0_ovf_i,
  input wire logic eci_i,
  input wire logic ext_clk_i,
  input wire logic idle_i,
  input wire logic [4:0] module_match_i,
  output logic wdt_rst_o,
  output logic array_irq_o,
  output logic irq_o
);
  import cawd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.
  cawd_regbus_if bus ();

  cawd_apb u_apb (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .psel_i (psel_i),
    .penable_i (penable_i),
    .pwrite_i (pwrite_i),
    .paddr_i (paddr_i),
    .pwdata_i (pwdata_i),
    .prdata_o (prdata_o),
    .pready_o (pready_o),
    .pslverr_o (pslverr_o),
    .bus (bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic cf_q;
  logic run_q;
  logic [4:0] ccf_q;
  logic [4:0] ccf_d;
  logic idle_suspend_bit_q;
  logic watchdog_enable_bit_q;
  logic lock_q;
  logic [2:0] cps_q;
  logic ecf_q;
  cawd_byte_t ofs_q;
  cawd_byte_t upd_q;
  logic [4:0] mod_ie_q;
  logic [5:0] st_q;
  logic [5:0] st_d;
  logic [5:0] msk_q;
  logic wdt_rst_q;
  logic array_irq_q;
  logic irq_q;
  logic tb_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  wire wr_ctrl = bus.wr && bus.addr == `CAWD_OFF_CTRL;
  wire wr_mode = bus.wr && bus.addr == `CAWD_OFF_MODE;
  wire wr_lo = bus.wr && bus.addr == `CAWD_OFF_CNT_LO;
  wire wr_hi = bus.wr && bus.addr == `CAWD_OFF_CNT_HI;
  wire wr_ofs = bus.wr && bus.addr == `CAWD_OFF_WD_OFS;
  wire wr_upd = bus.wr && bus.addr == `CAWD_OFF_WD_UPD;
  wire wr_st = bus.wr && bus.addr == `CAWD_OFF_IRQ_ST;
  wire wr_msk = bus.wr && bus.addr == `CAWD_OFF_IRQ_MSK;
  wire wr_ie = bus.wr && bus.addr == `CAWD_OFF_MOD_IE;

  assign bus.hit = bus.addr == `CAWD_OFF_CTRL || bus.addr == `CAWD_OFF_MODE ||
                   bus.addr == `CAWD_OFF_CNT_LO || bus.addr == `CAWD_OFF_CNT_HI ||
                   bus.addr == `CAWD_OFF_WD_OFS || bus.addr == `CAWD_OFF_WD_UPD ||
                   bus.addr == `CAWD_OFF_IRQ_ST || bus.addr == `CAWD_OFF_IRQ_MSK ||
                   bus.addr == `CAWD_OFF_MOD_IE;

  // Control bit 5 and mode bit 4 always read as zero.
  wire [7:0] ctrl_rd = {cf_q, run_q, 1'b0, ccf_q};
  wire [7:0] mode_rd = {idle_suspend_bit_q, watchdog_enable_bit_q, lock_q, 1'b0, cps_q, ecf_q};
  assign bus.rdata = (bus.addr == `CAWD_OFF_CTRL) ? ctrl_rd :
                     (bus.addr == `CAWD_OFF_MODE) ? mode_rd :
                     (bus.addr == `CAWD_OFF_CNT_LO) ? cnt_q[7:0] :
                     (bus.addr == `CAWD_OFF_CNT_HI) ? cnt_q[15:8] :
                     (bus.addr == `CAWD_OFF_WD_OFS) ? ofs_q :
                     (bus.addr == `CAWD_OFF_WD_UPD) ? upd_q :
                     (bus.addr == `CAWD_OFF_IRQ_ST) ? {2'h0, st_q} :
                     (bus.addr == `CAWD_OFF_IRQ_MSK) ? {2'h0, msk_q} :
                     (bus.addr == `CAWD_OFF_MOD_IE) ? {3'h0, mod_ie_q} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Timebase and counter.
  cawd_timebase u_tb (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .sel_i (cps_q),
    .timer0_ovf_i (timer0_ovf_i),
    .eci_i (eci_i),
    .ext_clk_i (ext_clk_i),
    .tick_o (tb_tick)
  );

  wire wd_en = watchdog_enable_bit_q | lock_q;
  wire suspend = idle_suspend_bit_q & idle_i;
  wire cnt_tick = tb_tick & (run_q | wd_en) & ~suspend;
  wire lo_ovf = cnt_tick & (cnt_q[7:0] == `CAWD_LO_MAX);
  wire full_ovf = cnt_tick & (cnt_q == `CAWD_CNT_MAX);
  wire [7:0] upd_calc = cnt_q[15:8] + ofs_q;

  // Counter writes are dropped while the watchdog guards the count.
  assign cnt_d = cnt_tick ? cnt_q + 16'h0001 :
                 (wr_lo & ~wd_en) ? {cnt_q[15:8], bus.wdata} :
                 (wr_hi & ~wd_en) ? {bus.wdata, cnt_q[7:0]} : cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog.
  wire wd_match = wd_en & lo_ovf & (upd_q == cnt_q[15:8]);
  wire wd_force = wd_en & wr_ctrl & bus.wdata[`CAWD_CTRL_WDF];

  // Module 4 is the watchdog while enabled, so its external match is masked.
  wire [4:0] hw_match = module_match_i & ~{wd_en, 4'h0};
  wire [5:0] events = {hw_match, full_ovf};

  genvar gi;
  generate
    for (gi = 0; gi < `CAWD_NUM_MOD; gi = gi + 1) begin : g_ccf
      // A hardware match beats a software clear in the same cycle.
      assign ccf_d[gi] = hw_match[gi] | (wr_ctrl ? bus.wdata[gi] : ccf_q[gi]);
    end
    for (gi = 0; gi < `CAWD_NUM_EV; gi = gi + 1) begin : g_st
      assign st_d[gi] = events[gi] | (st_q[gi] & ~(wr_st & bus.wdata[gi]));
    end
  endgenerate

  // Mode register write filtering.
  wire mode_open = wr_mode & ~watchdog_enable_bit_q;
  wire frz_open = mode_open & ~lock_q;
  wire lock_d = lock_q | (mode_open & bus.wdata[`CAWD_MODE_LOCK]);
  wire watchdog_enable_bit_d = ~wr_mode ? watchdog_enable_bit_q :
                lock_q ? (watchdog_enable_bit_q | bus.wdata[`CAWD_MODE_WATCHDOG_ENABLE_BIT]) :
                bus.wdata[`CAWD_MODE_WATCHDOG_ENABLE_BIT];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_q <= `CAWD_CNT_RST;
      cf_q <= 1'b0;
      run_q <= 1'b0;
      ccf_q <= 5'h00;
      st_q <= 6'h00;
      msk_q <= 6'h00;
      mod_ie_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
      cf_q <= full_ovf | (wr_ctrl ? bus.wdata[`CAWD_CTRL_OVF] : cf_q);
      run_q <= wr_ctrl ? bus.wdata[`CAWD_CTRL_RUN] : run_q;
      ccf_q <= ccf_d;
      st_q <= st_d;
      msk_q <= wr_msk ? bus.wdata[5:0] : msk_q;
      mod_ie_q <= wr_ie ? bus.wdata[4:0] : mod_ie_q;
    end
  end

  // Mode reset value held as a typed constant so that the unused bit 4 can be sliced out.
  localparam logic [7:0] mode_rst_c = `CAWD_MODE_RST;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {idle_suspend_bit_q, watchdog_enable_bit_q, lock_q, cps_q, ecf_q} <= {mode_rst_c[7:5], mode_rst_c[3:0]};
    end else begin
      watchdog_enable_bit_q <= watchdog_enable_bit_d;
      lock_q <= lock_d;
      idle_suspend_bit_q <= frz_open ? bus.wdata[`CAWD_MODE_IDLE] : idle_suspend_bit_q;
      cps_q <= frz_open ? bus.wdata[`CAWD_MODE_CPS_LSB +: 3] : cps_q;
      ecf_q <= mode_open ? bus.wdata[`CAWD_MODE_ECF] : ecf_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ofs_q <= `CAWD_BYTE_RST;
      upd_q <= `CAWD_BYTE_RST;
      wdt_rst_q <= 1'b0;
      array_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ofs_q <= wr_ofs ? bus.wdata : ofs_q;
      upd_q <= wr_upd ? upd_calc : upd_q;
      wdt_rst_q <= wd_match | wd_force;
      array_irq_q <= (cf_q & ecf_q) | (|(ccf_q & mod_ie_q));
      irq_q <= |(st_q & msk_q);
    end
  end

  assign wdt_rst_o = wdt_rst_q;
  assign array_irq_o = array_irq_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Cycles since reset with no register write; tracks the default timeout.
  logic [12:0] cyc_q;
  logic quiet_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cyc_q <= 13'h0000;
      quiet_q <= 1'b1;
    end else begin
      cyc_q <= (cyc_q == 13'h1FFF) ? cyc_q : cyc_q + 13'h0001;
      quiet_q <= quiet_q & ~bus.wr & ~wdt_rst_q;
    end
  end

  wd_match_rst_a: assert property (wd_en && lo_ovf && upd_q == cnt_q[15:8] |=> wdt_rst_o)
    else $error("watchdog match did not reset");
  wd_force_rst_a: assert property (wr_ctrl && bus.wdata[4] && wd_en |=> wdt_rst_o)
    else $error("forced watchdog reset missing");
  wd_cause_a: assert property (wdt_rst_o |-> $past(wd_en))
    else $error("watchdog reset while disabled");
  tb_frozen_a: assert property (wd_en |=> $stable(cps_q) && $stable(idle_suspend_bit_q))
    else $error("timebase changed while watchdog enabled");
  lock_holds_a: assert property (lock_q |=> lock_q && wd_en)
    else $error("locked watchdog was disabled");
  wd_disable_a: assert property (wr_mode && !lock_q && !bus.wdata[6] && !bus.wdata[5] |=> !wd_en)
    else $error("watchdog not disabled by write");
  reset_vals_a: assert property (disable iff (1'b0)
    !rst_n_i |=> watchdog_enable_bit_q && cps_q == 3'h0 && cnt_q[7:0] == 8'h00 && ofs_q == 8'h00)
    else $error("wrong reset values");
  dflt_timeout_a: assert property (quiet_q && wdt_rst_o |-> cyc_q >= 13'd3072 && cyc_q <= 13'd3075)
    else $error("default timeout not 3072 cycles");
  dflt_fires_a: assert property (quiet_q |-> cyc_q < 13'd3080)
    else $error("default timeout never fired");
  ovf_set_a: assert property (full_ovf |=> cf_q ##1 (cf_q || $past(wr_ctrl)))
    else $error("overflow flag not set or lost");
  ovf_irq_a: assert property (cf_q && ecf_q |=> array_irq_o)
    else $error("overflow interrupt not raised");
  run_stop_a: assert property (!run_q && !wd_en && !wr_lo && !wr_hi |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  ctrl_bit5_a: assert property (bus.addr == `CAWD_OFF_CTRL |-> !bus.rdata[5])
    else $error("control bit 5 read as one");
  ccf_set_a: assert property (hw_match[0] |=> ccf_q[0])
    else $error("module flag not set on match");
  upd_load_a: assert property (wr_upd |=> upd_q == $past(upd_calc))
    else $error("update register wrong value");
  cnt_guard_a: assert property (wd_en && (wr_lo || wr_hi) && !cnt_tick |=> $stable(cnt_q))
    else $error("counter written while watchdog enabled");
  mode_frozen_a: assert property (watchdog_enable_bit_q && wr_mode |=> $stable(ecf_q) && $stable(cps_q) && $stable(idle_suspend_bit_q))
    else $error("mode bits changed while enabled");

  ////////////////////////////////////////////////////////////////////////////////
  // Flags, counting and the reset output, cycle by cycle.
  ccf_hw_wins_a: assert property (
    hw_match[1] && wr_ctrl && !bus.wdata[1] |=> ccf_q[1])
    else $error("software clear beat a module match");
  ovf_hw_wins_a: assert property (
    full_ovf && wr_ctrl |=> cf_q)
    else $error("software clear beat the overflow");
  cf_sticky_a: assert property (
    cf_q && !wr_ctrl |=> cf_q)
    else $error("overflow flag cleared by hardware");
  ccf_sticky_a: assert property (
    ccf_q[0] && !wr_ctrl |=> ccf_q[0])
    else $error("module flag cleared by hardware");
  ccf_irq_a: assert property (
    (|(ccf_q & mod_ie_q)) |=> array_irq_o)
    else $error("module interrupt not raised");
  irq_quiet_a: assert property (
    !cf_q && ccf_q == 5'h00 |=> !array_irq_o)
    else $error("array interrupt without a flag");
  wd_runs_a: assert property (
    wd_en && tb_tick && !suspend |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter not forced on by watchdog");
  run_count_a: assert property (
    run_q && tb_tick && !suspend |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not count while running");
  lo_wrap_a: assert property (
    lo_ovf |=> cnt_q[7:0] == 8'h00)
    else $error("low byte did not wrap to zero");
  full_wrap_a: assert property (
    full_ovf |=> cnt_q == 16'h0000)
    else $error("counter did not wrap to zero");
  idle_hold_a: assert property (
    suspend && !wr_lo && !wr_hi |=> $stable(cnt_q))
    else $error("counter moved while idle suspended");
  no_spurious_rst_a: assert property (
    !wd_match && !wd_force |=> !wdt_rst_o)
    else $error("watchdog reset without a cause");
  lock_frozen_a: assert property (
    watchdog_enable_bit_q && wr_mode |=> lock_q == $past(lock_q))
    else $error("lock bit changed while enabled");
  watchdog_enable_bit_locked_a: assert property (
    watchdog_enable_bit_q && lock_q |=> watchdog_enable_bit_q)
    else $error("enable bit cleared while locked");
  upd_hold_a: assert property (
    !wr_upd |=> $stable(upd_q))
    else $error("update register changed without a write");
  st_ovf_a: assert property (
    full_ovf |=> st_q[0])
    else $error("overflow status not set");
  irq_follow_a: assert property (
    (|(st_q & msk_q)) |=> irq_o)
    else $error("masked interrupt not raised");
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking testbench for the counter-array watchdog top module.
`timescale 1ns/1ps
`default_nettype none
`include "cawd_params.svh"
module tb_top;
  import cawd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  cawd_addr_t paddr_i = 8'h00;
  cawd_word_t pwdata_i = 32'h00000000;
  cawd_word_t prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic timer0_ovf_i = 1'b0;
  logic eci_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic idle_i = 1'b0;
  logic [4:0] module_match_i = 5'h00;
  logic wdt_rst_o;
  logic array_irq_o;
  logic irq_o;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int npulse = 0;
  int last_pulse = 0;
  logic [7:0] ph = 8'h00;
  cawd_byte_t rd;
  logic err;

  cawd_top dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .timer0_ovf_i(timer0_ovf_i), .eci_i(eci_i),
    .ext_clk_i(ext_clk_i), .idle_i(idle_i), .module_match_i(module_match_i),
    .wdt_rst_o(wdt_rst_o), .array_irq_o(array_irq_o), .irq_o(irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Free-running count sources: timer pulse one in four, input falls one in eight.
  always @(posedge clk_sys_i) begin
    ph <= ph + 8'h01;
    timer0_ovf_i <= (ph[1:0] == 2'h3);
    eci_i <= ph[2];
    ext_clk_i <= ph[1];
    cyc <= rst_n_i ? cyc + 1 : 0;
    if (wdt_rst_o === 1'b1) begin
      npulse <= npulse + 1;
      last_pulse <= cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_r(input logic [31:0] got, input int lo, input int hi);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic wr, input cawd_addr_t a, input cawd_byte_t d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk(32'(pready_o), 32'h1);
  endtask

  task automatic wr(input cawd_addr_t a, input cawd_byte_t d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input cawd_addr_t a, input cawd_byte_t exp);
    apb(1'b0, a, 8'h00);
    chk({24'h000000, rd}, {24'h000000, exp});
  endtask

  task automatic wait_pulse(input int lim);
    int p0;
    int n;
    p0 = npulse;
    n = 0;
    while (npulse == p0 && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask

  task automatic force_rst(input cawd_byte_t v, input int exp);
    int p0;
    p0 = npulse;
    wr(`CAWD_OFF_CTRL, v);
    repeat (4) @(posedge clk_sys_i);
    chk(npulse - p0, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    do_reset();
    rdc(`CAWD_OFF_CNT_LO, 8'h00);
    rdc(`CAWD_OFF_WD_OFS, 8'h00);
    rdc(`CAWD_OFF_MODE, 8'h40);
    rdc(`CAWD_OFF_CTRL, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk(32'(err), 32'h1);
    chk({24'h000000, rd}, 32'h0);
    wait_pulse(4000);
    chk_r(last_pulse, 3070, 3078);
  endtask

  task automatic t_update;
    do_reset();
    wr(`CAWD_OFF_WD_OFS, 8'h02);
    wr(`CAWD_OFF_WD_UPD, 8'hAB);
    rdc(`CAWD_OFF_WD_UPD, 8'h02);
    wait_pulse(10000);
    chk_r(last_pulse, 9214, 9222);
  endtask

  task automatic t_lock_force;
    cawd_byte_t v1;
    do_reset();
    wr(`CAWD_OFF_MODE, 8'h49);
    rdc(`CAWD_OFF_MODE, 8'h40);
    force_rst(8'h10, 1);
    wr(`CAWD_OFF_MODE, 8'h00);
    rdc(`CAWD_OFF_MODE, 8'h00);
    wr(`CAWD_OFF_CTRL, 8'h00);
    force_rst(8'h10, 0);
    wr(`CAWD_OFF_CTRL, 8'h00);
    wr(`CAWD_OFF_MODE, 8'h20);
    wr(`CAWD_OFF_MODE, 8'h88);
    rdc(`CAWD_OFF_MODE, 8'h20);
    wr(`CAWD_OFF_CNT_HI, 8'h77);
    rdc(`CAWD_OFF_CNT_HI, 8'h00);
    apb(1'b0, `CAWD_OFF_CNT_LO, 8'h00);
    v1 = rd;
    repeat (48) @(posedge clk_sys_i);
    apb(1'b0, `CAWD_OFF_CNT_LO, 8'h00);
    chk_r(8'(rd - v1), 3, 6);
    force_rst(8'h10, 1);
  endtask

  task automatic t_flags;
    cawd_byte_t v1;
    do_reset();
    wr(`CAWD_OFF_MODE, 8'h00);
    wr(`CAWD_OFF_MODE, 8'h09);
    wr(`CAWD_OFF_CNT_LO, 8'hF0);
    wr(`CAWD_OFF_CNT_HI, 8'hFF);
    repeat (20) @(posedge clk_sys_i);
    rdc(`CAWD_OFF_CNT_LO, 8'hF0);
    wr(`CAWD_OFF_IRQ_MSK, 8'h01);
    wr(`CAWD_OFF_CTRL, 8'h40);
    repeat (30) @(posedge clk_sys_i);
    rdc(`CAWD_OFF_CTRL, 8'hC0);
    chk(32'(array_irq_o), 32'h1);
    chk(32'(irq_o), 32'h1);
    rdc(`CAWD_OFF_IRQ_ST, 8'h01);
    wr(`CAWD_OFF_IRQ_ST, 8'h01);
    wr(`CAWD_OFF_MODE, 8'h08);
    repeat (3) @(posedge clk_sys_i);
    chk(32'(irq_o), 32'h0);
    chk(32'(array_irq_o), 32'h0);
    rdc(`CAWD_OFF_CTRL, 8'hC0);
    wr(`CAWD_OFF_CTRL, 8'h60);
    rdc(`CAWD_OFF_CTRL, 8'h40);
    wr(`CAWD_OFF_MOD_IE, 8'h01);
    @(posedge clk_sys_i);
    module_match_i <= 5'h01;
    @(posedge clk_sys_i);
    module_match_i <= 5'h00;
    repeat (3) @(posedge clk_sys_i);
    chk(32'(array_irq_o), 32'h1);
    chk(32'(irq_o), 32'h0);
    rdc(`CAWD_OFF_CTRL, 8'h41);
    wr(`CAWD_OFF_CTRL, 8'h40);
    rdc(`CAWD_OFF_CTRL, 8'h40);
    // Idle suspension: the running counter must hold while the core idles.
    wr(`CAWD_OFF_MODE, 8'h88);
    idle_i <= 1'b1;
    apb(1'b0, `CAWD_OFF_CNT_LO, 8'h00);
    v1 = rd;
    repeat (10) @(posedge clk_sys_i);
    rdc(`CAWD_OFF_CNT_LO, v1);
    idle_i <= 1'b0;
  endtask

  task automatic t_timebase;
    int per[6] = '{12, 4, 4, 8, 1, 32};
    int t0;
    int e;
    do_reset();
    wr(`CAWD_OFF_MODE, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(`CAWD_OFF_CTRL, 8'h00);
      wr(`CAWD_OFF_MODE, {4'h0, 3'(i), 1'b0});
      wr(`CAWD_OFF_CNT_LO, 8'h00);
      wr(`CAWD_OFF_CNT_HI, 8'h00);
      wr(`CAWD_OFF_CTRL, 8'h40);
      t0 = cyc;
      repeat (96) @(posedge clk_sys_i);
      wr(`CAWD_OFF_CTRL, 8'h00);
      e = (cyc - t0) / per[i];
      apb(1'b0, `CAWD_OFF_CNT_LO, 8'h00);
      chk_r({24'h000000, rd}, e - 1, e + 1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset_vals();
    t_update();
    t_lock_force();
    t_flags();
    t_timebase();
    wrap_up();
  end

  initial begin
    #(40 * 40000);
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
